// ===== rtl/irq_gate.sv
// Interrupt enable registers, request gating and wake-up decision for the CPU core.
//
// Function
// - Global gate off masks all requests.
// - PWM channel needs own and group enable.
// - Channel 2 enable is clear register bit 7.
// - Channel 0 enable is output-enable register bit 6.
// - Pin 0/1 enables gate interrupt and wake.
// - Main register holds Timer0-2 and UART1 enables.
// - Extended register holds peripheral and PWM enables.
// - Pins 2-9/low-voltage enable gates irq and wake.
// - Port1 enable gates interrupt, never wake.
// - Timer3 enable gates irq and Halt wake.
// - Enables gate servicing, not flag setting.
// - Idle any, Stop pins, Halt pins plus Timer3.
`timescale 1ns/1ps
`default_nettype none
`include "irq_gate_map.svh"

module irq_gate (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic [15:0] src_flag,
    input wire logic pins_2to9_wake_req,
    input wire logic port_one_wake_req,
    output logic [15:0] irq_req,
    output logic [5:0] pwm_out_en,
    output logic [5:0] pwm_clr,
    output logic wake_idle,
    output logic wake_stop,
    output logic wake_halt
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    irq_gate_pkg::state_s s_q;
    irq_gate_pkg::state_s s_d;

    logic global_irq_gate;
    logic pin0_irq_wake_on;
    logic pin1_irq_wake_on;
    logic pins_2to9_lowvolt_irq_on;
    logic port_one_change_irq_on;
    logic timer_three_irq_wake_on;
    logic pwm_group_irq_on;
    logic pwm_ch0_irq_on;
    logic pwm_ch1_irq_on;
    logic pwm_ch2_irq_on;
    logic [15:0] src_en;
    logic [15:0] req_now;
    logic stop_wake_now;

    assign global_irq_gate = s_q.main_irq_enable[`MAIN_GLOBAL_BIT];
    assign pin0_irq_wake_on = s_q.main_irq_enable[`MAIN_PIN0_BIT];
    assign pin1_irq_wake_on = s_q.main_irq_enable[`MAIN_PIN1_BIT];
    assign pins_2to9_lowvolt_irq_on = s_q.extended_irq_enable[`EXT_PINLV_BIT];
    assign port_one_change_irq_on = s_q.extended_irq_enable[`EXT_P1_BIT];
    assign timer_three_irq_wake_on = s_q.extended_irq_enable[`EXT_T3_BIT];
    assign pwm_group_irq_on = s_q.extended_irq_enable[`EXT_PWM_BIT];
    assign pwm_ch0_irq_on = s_q.pwm_out_en[`PWMOE_CH0_BIT];
    assign pwm_ch1_irq_on = s_q.pwm_out_en[`PWMOE_CH1_BIT];
    assign pwm_ch2_irq_on = s_q.pwm_clr_ch2[`PWM_CLEAR_AND_CH2_IRQ_EN_CH2_BIT];

    // ----------------------------------------------------------------
    // Per-source enable map
    // ----------------------------------------------------------------
    always_comb
    begin
        src_en = 16'h0000;
        src_en[`SRC_PIN0] = pin0_irq_wake_on;
        src_en[`SRC_T0] = s_q.main_irq_enable[`MAIN_T0_BIT];
        src_en[`SRC_PIN1] = pin1_irq_wake_on;
        src_en[`SRC_T1] = s_q.main_irq_enable[`MAIN_T1_BIT];
        src_en[`SRC_UART1] = s_q.main_irq_enable[`MAIN_UART1_BIT];
        src_en[`SRC_T2] = s_q.main_irq_enable[`MAIN_T2_BIT];
        src_en[`SRC_T3] = timer_three_irq_wake_on;
        src_en[`SRC_P1] = port_one_change_irq_on;
        src_en[`SRC_PINLV] = pins_2to9_lowvolt_irq_on;
        src_en[`SRC_ADTK] = s_q.extended_irq_enable[`EXT_ADTK_BIT];
        src_en[`SRC_SPI] = s_q.extended_irq_enable[`EXT_SPI_BIT];
        src_en[`SRC_UART2] = s_q.extended_irq_enable[`EXT_UART2_BIT];
        src_en[`SRC_I2C] = s_q.extended_irq_enable[`EXT_I2C_BIT];
        src_en[`SRC_PWM0] = pwm_ch0_irq_on & pwm_group_irq_on;
        src_en[`SRC_PWM1] = pwm_ch1_irq_on & pwm_group_irq_on;
        src_en[`SRC_PWM2] = pwm_ch2_irq_on & pwm_group_irq_on;
    end

    // Flags are owned by the peripherals; nothing here ever clears or blocks their setting.
    assign req_now = src_flag & src_en & {16{global_irq_gate}};

    // Stop and Halt wake paths bypass the global gate so a sleeping core with interrupts off can still resume; Idle wake does not.
    // Port1 wake is qualified by its per-pin enables outside and ignores the change enable.
    assign stop_wake_now = (src_flag[`SRC_PIN0] & pin0_irq_wake_on)
                         | (src_flag[`SRC_PIN1] & pin1_irq_wake_on)
                         | (pins_2to9_wake_req & pins_2to9_lowvolt_irq_on)
                         | port_one_wake_req;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    // ----------------------------------------------------------------
    // Register file, read mux and registered outputs
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        if (sfr_wr && hit(sfr_addr, `PWM_OUT_EN_ADDR))
        begin
            s_d.pwm_out_en = sfr_wdata;
        end
        else if (sfr_wr && hit(sfr_addr, `PWM_CLR_CH2_ADDR))
        begin
            s_d.pwm_clr_ch2 = sfr_wdata & `PWM_CLR_CH2_WMASK;
        end
        else if (sfr_wr && hit(sfr_addr, `MAIN_IRQ_EN_ADDR))
        begin
            s_d.main_irq_enable = sfr_wdata & `MAIN_IRQ_EN_WMASK;
        end
        else if (sfr_wr && hit(sfr_addr, `EXT_IRQ_EN_ADDR))
        begin
            s_d.extended_irq_enable = sfr_wdata;
        end
        if (hit(sfr_addr, `PWM_OUT_EN_ADDR))
        begin
            s_d.rdata = s_q.pwm_out_en;
        end
        else if (hit(sfr_addr, `PWM_CLR_CH2_ADDR))
        begin
            s_d.rdata = s_q.pwm_clr_ch2;
        end
        else if (hit(sfr_addr, `MAIN_IRQ_EN_ADDR))
        begin
            s_d.rdata = s_q.main_irq_enable;
        end
        else if (hit(sfr_addr, `EXT_IRQ_EN_ADDR))
        begin
            s_d.rdata = s_q.extended_irq_enable;
        end
        else
        begin
            s_d.rdata = 8'h00;
        end
        s_d.req = req_now;
        s_d.wake_idle = |req_now;
        s_d.wake_stop = stop_wake_now;
        s_d.wake_halt = stop_wake_now | (src_flag[`SRC_T3] & timer_three_irq_wake_on);
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign sfr_rdata = s_q.rdata;
    assign irq_req = s_q.req;
    assign pwm_out_en = s_q.pwm_out_en[5:0];
    assign pwm_clr = s_q.pwm_clr_ch2[5:0];
    assign wake_idle = s_q.wake_idle;
    assign wake_stop = s_q.wake_stop;
    assign wake_halt = s_q.wake_halt;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_global_mask;
        @(posedge sys_clk) disable iff (rst)
        !s_q.main_irq_enable[7] |=> (irq_req == 16'h0000);
    endproperty
    a_global_mask: assert property (p_global_mask) else $error("request passed with global gate off");

    property p_pwm_group;
        @(posedge sys_clk) disable iff (rst)
        !s_q.extended_irq_enable[7] |=> (irq_req[15:13] == 3'h0);
    endproperty
    a_pwm_group: assert property (p_pwm_group) else $error("pwm request without group enable");

    property p_pwm2_pass;
        @(posedge sys_clk) disable iff (rst)
        (s_q.main_irq_enable[7] && s_q.extended_irq_enable[7] && s_q.pwm_clr_ch2[7]
            && src_flag[15]) |=> irq_req[15];
    endproperty
    a_pwm2_pass: assert property (p_pwm2_pass) else $error("pwm channel 2 request lost");

    property p_pwm0_block;
        @(posedge sys_clk) disable iff (rst)
        !s_q.pwm_out_en[6] |=> !irq_req[13];
    endproperty
    a_pwm0_block: assert property (p_pwm0_block) else $error("pwm channel 0 passed while off");

    property p_pin0_wake;
        @(posedge sys_clk) disable iff (rst)
        (src_flag[0] && s_q.main_irq_enable[0]) |=> (wake_stop && wake_halt);
    endproperty
    a_pin0_wake: assert property (p_pin0_wake) else $error("pin 0 did not wake");

    property p_write_main;
        @(posedge sys_clk) disable iff (rst)
        (sfr_wr && sfr_addr == `MAIN_IRQ_EN_ADDR) ##1 (sfr_addr == `MAIN_IRQ_EN_ADDR)
            |=> (sfr_rdata == ($past(sfr_wdata, 2) & `MAIN_IRQ_EN_WMASK));
    endproperty
    a_write_main: assert property (p_write_main) else $error("main enable readback wrong");

    property p_uart2_pass;
        @(posedge sys_clk) disable iff (rst)
        (s_q.main_irq_enable[7] && s_q.extended_irq_enable[5] && src_flag[11]) |=> irq_req[11];
    endproperty
    a_uart2_pass: assert property (p_uart2_pass) else $error("uart two request lost");

    property p_pinlv_wake;
        @(posedge sys_clk) disable iff (rst)
        (!s_q.main_irq_enable[7] && s_q.extended_irq_enable[2] && pins_2to9_wake_req)
            |=> wake_stop;
    endproperty
    a_pinlv_wake: assert property (p_pinlv_wake) else $error("pin group did not wake");

    property p_port1_wake;
        @(posedge sys_clk) disable iff (rst)
        (port_one_wake_req && !s_q.extended_irq_enable[1]) |=> (wake_stop && !irq_req[7]);
    endproperty
    a_port1_wake: assert property (p_port1_wake) else $error("port one wake mishandled");

    property p_t3_halt;
        @(posedge sys_clk) disable iff (rst)
        (src_flag[6] && s_q.extended_irq_enable[0]) |=> wake_halt;
    endproperty
    a_t3_halt: assert property (p_t3_halt) else $error("timer three did not wake halt");

    property p_idle_any;
        @(posedge sys_clk) disable iff (rst)
        (src_flag[1] && s_q.main_irq_enable[1] && s_q.main_irq_enable[7]) |=> wake_idle;
    endproperty
    a_idle_any: assert property (p_idle_any) else $error("enabled request missed idle wake");

    property p_and_form;
        @(posedge sys_clk) disable iff (rst)
        1'b1 |=> (irq_req & ~$past(src_flag)) == 16'h0000;
    endproperty
    a_and_form: assert property (p_and_form) else $error("request without flag");

    c_pwm2: cover property (@(posedge sys_clk) disable iff (rst) irq_req[15]);
    c_wake_no_gate: cover property (@(posedge sys_clk) disable iff (rst)
        wake_stop && !s_q.main_irq_enable[7]);
    c_t3_halt_only: cover property (@(posedge sys_clk) disable iff (rst) wake_halt && !wake_stop);

endmodule

`default_nettype wire

// ===== pkg/irq_gate_map.svh
// Register offsets, field positions, reset values and source indices of the interrupt gate.
`ifndef IRQ_GATE_MAP_SVH
`define IRQ_GATE_MAP_SVH

// ----------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------
`define PWM_OUT_EN_ADDR 8'h9e
`define PWM_CLR_CH2_ADDR 8'h9f
`define MAIN_IRQ_EN_ADDR 8'ha8
`define EXT_IRQ_EN_ADDR 8'ha9
`define REG_RESET 8'h00
`define MAIN_IRQ_EN_WMASK 8'hbf
`define PWM_CLR_CH2_WMASK 8'hbf

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MAIN_PIN0_BIT 0
`define MAIN_T0_BIT 1
`define MAIN_PIN1_BIT 2
`define MAIN_T1_BIT 3
`define MAIN_UART1_BIT 4
`define MAIN_T2_BIT 5
`define MAIN_GLOBAL_BIT 7
`define EXT_T3_BIT 0
`define EXT_P1_BIT 1
`define EXT_PINLV_BIT 2
`define EXT_ADTK_BIT 3
`define EXT_SPI_BIT 4
`define EXT_UART2_BIT 5
`define EXT_I2C_BIT 6
`define EXT_PWM_BIT 7
`define PWMOE_CH0_BIT 6
`define PWMOE_CH1_BIT 7
`define PWM_CLEAR_AND_CH2_IRQ_EN_CH2_BIT 7

// ----------------------------------------------------------------
// Source indices of the flag and request vectors
// ----------------------------------------------------------------
`define SRC_COUNT 16
`define SRC_PIN0 0
`define SRC_T0 1
`define SRC_PIN1 2
`define SRC_T1 3
`define SRC_UART1 4
`define SRC_T2 5
`define SRC_T3 6
`define SRC_P1 7
`define SRC_PINLV 8
`define SRC_ADTK 9
`define SRC_SPI 10
`define SRC_UART2 11
`define SRC_I2C 12
`define SRC_PWM0 13
`define SRC_PWM1 14
`define SRC_PWM2 15

`endif

// ===== pkg/irq_gate_pkg.sv
// Types shared by the interrupt enable and wake gating block.
package irq_gate_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [15:0] src_t;

    typedef struct packed {
        byte_t pwm_out_en;
        byte_t pwm_clr_ch2;
        byte_t main_irq_enable;
        byte_t extended_irq_enable;
        byte_t rdata;
        src_t req;
        logic wake_idle;
        logic wake_stop;
        logic wake_halt;
    } state_s;

endpackage

// ===== tb/flag_source.sv
// Behavioural model of the peripheral flag sources and pin wake lines seen by the gate.
`timescale 1ns/1ps
`default_nettype none

module flag_source (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] event_pulse,
    input wire logic [15:0] clear_mask,
    input wire logic pins_event,
    input wire logic port_event,
    output logic [15:0] src_flag,
    output logic pins_2to9_wake_req,
    output logic port_one_wake_req
);
    // Flags latch on events whatever the enables say, so a masked source stays pending.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            src_flag <= 16'h0000;
            pins_2to9_wake_req <= 1'b0;
            port_one_wake_req <= 1'b0;
        end
        else
        begin
            src_flag <= (src_flag & ~clear_mask) | event_pulse;
            pins_2to9_wake_req <= pins_event;
            port_one_wake_req <= port_event;
        end
    end
endmodule

`default_nettype wire

// ===== tb/testbench.sv
// Self-checking testbench of the interrupt enable and wake gating block.
`timescale 1ns/1ps
`default_nettype none
`include "irq_gate_map.svh"

`define CHK(nm, exp, got) \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
        errors++; \
        $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end

module testbench;
    logic sys_clk;
    logic rst;
    logic [7:0] sfr_addr;
    logic sfr_wr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic [15:0] src_flag;
    logic pins_2to9_wake_req;
    logic port_one_wake_req;
    logic [15:0] irq_req;
    logic [5:0] pwm_out_en;
    logic [5:0] pwm_clr;
    logic wake_idle;
    logic wake_stop;
    logic wake_halt;
    logic [15:0] event_pulse;
    logic [15:0] clear_mask;
    logic pins_event;
    logic port_event;
    int errors;
    int comparisons;
    int cycles;

    irq_gate dut_u (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .src_flag(src_flag),
        .pins_2to9_wake_req(pins_2to9_wake_req), .port_one_wake_req(port_one_wake_req),
        .irq_req(irq_req), .pwm_out_en(pwm_out_en), .pwm_clr(pwm_clr),
        .wake_idle(wake_idle), .wake_stop(wake_stop), .wake_halt(wake_halt));

    flag_source partner_u (.sys_clk(sys_clk), .rst(rst), .event_pulse(event_pulse),
        .clear_mask(clear_mask), .pins_event(pins_event), .port_event(port_event),
        .src_flag(src_flag), .pins_2to9_wake_req(pins_2to9_wake_req),
        .port_one_wake_req(port_one_wake_req));

    // ----------------------------------------------------------------
    // Register access and closing tasks
    // ----------------------------------------------------------------
    // The strobe is left high so back-to-back writes never toggle it within one step.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        sfr_wr = 1'b0;
        sfr_addr = a;
        @(posedge sys_clk);
        #1;
        `CHK("sfr_rdata", exp, sfr_rdata)
    endtask

    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Loads the four enable registers and fresh flags, then checks gating two edges later.
    task automatic apply(input logic [31:0] cfg, input logic [15:0] fl, input logic pw,
        input logic p1w);
        logic [7:0] m;
        logic [7:0] x;
        logic [7:0] oe;
        logic [7:0] cl;
        logic [15:0] en;
        logic [15:0] req;
        logic stp;
        {m, x, oe, cl} = cfg;
        en = {cl[7], oe[7:6], x[6:0], m[5:0]};
        en[15:13] = en[15:13] & {3{x[7]}};
        req = fl & en & {16{m[7]}};
        stp = (fl[0] & m[0]) | (fl[2] & m[2]) | (pw & x[2]) | p1w;
        event_pulse = fl;
        clear_mask = 16'hffff;
        pins_event = pw;
        port_event = p1w;
        wr_reg(`MAIN_IRQ_EN_ADDR, m);
        event_pulse = 16'h0000;
        clear_mask = 16'h0000;
        wr_reg(`EXT_IRQ_EN_ADDR, x);
        wr_reg(`PWM_OUT_EN_ADDR, oe);
        wr_reg(`PWM_CLR_CH2_ADDR, cl);
        sfr_wr = 1'b0;
        @(posedge sys_clk);
        @(posedge sys_clk);
        #1;
        `CHK("irq_req", req, irq_req)
        `CHK("wake_stop", stp, wake_stop)
        `CHK("wake_halt", stp | (fl[6] & x[0]), wake_halt)
        `CHK("wake_idle", |req, wake_idle)
        `CHK("pwm_out_en", oe[5:0], pwm_out_en)
        `CHK("pwm_clr", cl[5:0], pwm_clr)
    endtask

    // ----------------------------------------------------------------
    // Clock and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            tally_and_finish;
        end
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial
    begin
        errors = 0;
        comparisons = 0;
        cycles = 0;
        rst = 1'b1;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        event_pulse = 16'h0000;
        clear_mask = 16'h0000;
        pins_event = 1'b0;
        port_event = 1'b0;
        repeat (12) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        rd_chk(`PWM_OUT_EN_ADDR, 8'h00);
        rd_chk(`PWM_CLR_CH2_ADDR, 8'h00);
        rd_chk(`MAIN_IRQ_EN_ADDR, 8'h00);
        rd_chk(`EXT_IRQ_EN_ADDR, 8'h00);
        // The main register write is read straight back so the readback assertion is exercised.
        wr_reg(`PWM_CLR_CH2_ADDR, 8'hff);
        wr_reg(8'h80, 8'hff);
        wr_reg(`MAIN_IRQ_EN_ADDR, 8'hff);
        rd_chk(`MAIN_IRQ_EN_ADDR, 8'hbf);
        rd_chk(`PWM_CLR_CH2_ADDR, 8'hbf);
        rd_chk(8'h80, 8'h00);
        apply(32'hff_ff_c0_80, 16'hffff, 1'b1, 1'b1);
        apply(32'h7f_ff_ff_ff, 16'hffff, 1'b1, 1'b0);
        apply(32'hff_7f_c0_80, 16'hffff, 1'b0, 1'b1);
        apply(32'hff_80_00_00, 16'hffff, 1'b0, 1'b0);
        apply(32'hff_80_40_00, 16'he000, 1'b0, 1'b0);
        apply(32'hff_80_00_80, 16'he000, 1'b0, 1'b0);
        apply(32'hff_ff_ff_ff, 16'h0000, 1'b0, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            apply({8'h80 | (8'h01 << i), 24'h00_00_00}, 16'hffff, i[0], i[1]);
            apply({8'h80, 8'h01 << i, 16'hc0_80}, 16'hffff, i[1], i[0]);
        end
        // A reset in mid-run must drop every enable, request and wake line at once.
        rst = 1'b1;
        @(posedge sys_clk);
        #1;
        `CHK("irq_req", 16'h0000, irq_req)
        `CHK("wake_stop", 1'b0, wake_stop)
        `CHK("wake_halt", 1'b0, wake_halt)
        `CHK("pwm_clr", 6'h00, pwm_clr)
        rst = 1'b0;
        rd_chk(`EXT_IRQ_EN_ADDR, 8'h00);
        apply(32'hff_ff_c0_80, 16'hffff, 1'b1, 1'b1);
        tally_and_finish;
    end
endmodule

`default_nettype wire
